// [src/pslv_pkg.sv]
// Shared constants and types for the parallel slave port and its external host.
package pslv_pkg;
  // Register offsets on the APB bus (byte addresses, one word each).
  localparam logic [7:0] OFS_DATA_PORT = 8'h00;
  localparam logic [7:0] OFS_DATA_LATCH = 8'h04;
  localparam logic [7:0] OFS_DATA_DIR = 8'h08;
  localparam logic [7:0] OFS_CTL_PORT = 8'h0c;
  localparam logic [7:0] OFS_CTL_LATCH = 8'h10;
  localparam logic [7:0] OFS_CTL_STATUS = 8'h14;
  localparam logic [7:0] OFS_CORE_IRQ = 8'h18;
  localparam logic [7:0] OFS_IRQ_FLAG = 8'h1c;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;
  localparam logic [7:0] OFS_IRQ_PRIO = 8'h24;
  localparam logic [7:0] OFS_ANALOG_CFG = 8'h28;
  // Field positions in control_direction_and_status.
  localparam int BIT_IN_FULL = 7;
  localparam int BIT_OUT_FULL = 6;
  localparam int BIT_IN_OVERFLOW = 5;
  localparam int BIT_MODE = 4;
  // Slave port bit in the peripheral flag, enable and priority banks.
  localparam int BIT_SLV_IRQ = 7;
  // Control pin order on the three-pin bus.
  localparam int PIN_RD = 0;
  localparam int PIN_WR = 1;
  localparam int PIN_CS = 2;
  // Values after reset, and the writable bits of the analog configuration.
  localparam logic [7:0] RST_DATA_DIR = 8'hff;
  localparam logic [2:0] RST_CTL_DIR = 3'h7;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] ANALOG_CFG_MASK = 8'hcf;
  // Host cycle counts.
  localparam int STROBE_CYCLES = 8;
  localparam int RECOVER_CYCLES = 4;
  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_SETUP = 2'b01,
    HOST_STROBE = 2'b11,
    HOST_RECOVER = 2'b10
  } pslv_host_state_e;
endpackage

// [src/pslv_if.sv]
// Pin-level link between the slave port device and the external host.
`timescale 1ns/10ps
`default_nettype none
interface pslv_if;
  logic [7:0] data_dev_out;
  logic [7:0] data_dev_oe;
  logic [7:0] data_host_out;
  logic data_host_oe;
  logic [2:0] ctl_dev_out;
  logic [2:0] ctl_dev_oe;
  logic [2:0] ctl_host_out;
  logic [2:0] ctl_host_oe;
  logic [7:0] data;
  logic [2:0] ctl;
  // Undriven pins float high through pull-ups.
  assign data = (data_dev_oe & data_dev_out)
    | (~data_dev_oe & (data_host_oe ? data_host_out : 8'hff));
  assign ctl = (ctl_dev_oe & ctl_dev_out) | (~ctl_dev_oe & ctl_host_oe & ctl_host_out)
    | (~ctl_dev_oe & ~ctl_host_oe);
  modport device (
    input data,
    input ctl,
    output data_dev_out,
    output data_dev_oe,
    output ctl_dev_out,
    output ctl_dev_oe
  );
  modport host (
    input data,
    output data_host_out,
    output data_host_oe,
    output ctl_host_out,
    output ctl_host_oe
  );
endinterface
`default_nettype wire

// [src/pslv_host.sv]
// External processor end: issues asynchronous read and write strobes to the port.
`timescale 1ns/10ps
`default_nettype none
module pslv_host
  import pslv_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // User request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_data,
  output logic req_ready,
  // User response
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  // Pins
  pslv_if.host ifc
);
  pslv_host_state_e state;
  logic [3:0] cnt;
  logic is_write;
  logic [7:0] wdata;
  logic [2:0] ctl_out;
  logic data_oe;
  logic [7:0] data_meta;
  logic [7:0] data_sync;

  assign req_ready = (state == HOST_IDLE);
  assign ifc.ctl_host_out = ctl_out;
  assign ifc.ctl_host_oe = 3'h7;
  assign ifc.data_host_out = wdata;
  assign ifc.data_host_oe = data_oe;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_meta <= RST_ZERO;
      data_sync <= RST_ZERO;
    end
    else
    begin
      data_meta <= ifc.data;
      data_sync <= data_meta;
    end
  end

  // The strobe is held long enough for the device's synchroniser and our own.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= HOST_IDLE;
      cnt <= 4'h0;
      is_write <= 1'b0;
      wdata <= RST_ZERO;
      ctl_out <= 3'h7;
      data_oe <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= RST_ZERO;
    end
    else
    begin
      rsp_valid <= 1'b0;
      case (state)
        HOST_IDLE:
        begin
          if (req_valid)
          begin
            is_write <= req_write;
            wdata <= req_data;
            data_oe <= req_write;
            ctl_out[PIN_CS] <= 1'b0;
            state <= HOST_SETUP;
          end
        end
        HOST_SETUP:
        begin
          ctl_out[PIN_WR] <= ~is_write;
          ctl_out[PIN_RD] <= is_write;
          cnt <= 4'(STROBE_CYCLES - 1);
          state <= HOST_STROBE;
        end
        HOST_STROBE:
        begin
          if (cnt == 4'h0)
          begin
            if (!is_write)
            begin
              rsp_data <= data_sync;
            end
            rsp_valid <= 1'b1;
            ctl_out <= 3'h7;
            cnt <= 4'(RECOVER_CYCLES - 1);
            state <= HOST_RECOVER;
          end
          else
          begin
            cnt <= cnt - 4'h1;
          end
        end
        HOST_RECOVER:
        begin
          if (cnt == 4'h0)
          begin
            data_oe <= 1'b0;
            state <= HOST_IDLE;
          end
          else
          begin
            cnt <= cnt - 4'h1;
          end
        end
        default:
        begin
          state <= HOST_IDLE;
        end
      endcase
    end
  end
endmodule // pslv_host
`default_nettype wire

// [src/pslv_device.sv]
// Parallel slave port device: data and control pin ports, status, interrupt and APB slave.
// Overview of operation
// - Mode bit 4 selects slave port or GPIO.
// - Slave mode exposes data port as latch.
// - External side accesses latch without shared clock.
// - Write starts when select and write low.
// - Read starts when select and read low.
// - Host pulls read pin low to read.
// - Host pulls write pin low to write.
// - Host pulls select pin low to select.
// - Input full set on received word.
// - Output full until host reads word.
// - Overflow on write to unread word.
// - Low three bits set pin directions.
// - Bit 3 reads as zero.
// - Slave needs input pins and digital config.
// - Analog control pins read as zero.
// - Control pins analog after reset.
`timescale 1ns/10ps
`default_nettype none
module pslv_device
  import pslv_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupts
  output logic irq,
  output logic irq_high_priority,
  // Pins
  pslv_if.device ifc
);
  logic [10:0] pin_meta;
  logic [10:0] pin_sync;
  logic [7:0] pins_d;
  logic [2:0] pins_e;
  logic [7:0] data_latch;
  logic [7:0] data_dir;
  logic [2:0] ctl_latch;
  logic [2:0] ctl_dir;
  logic mode;
  logic input_buffer_full;
  logic output_buffer_full;
  logic input_overflow;
  logic [7:0] in_buf;
  logic [7:0] core_irq;
  logic irq_flag;
  logic irq_en;
  logic irq_prio;
  logic [7:0] analog_cfg;
  logic [7:0] data_oe;
  logic wr_q;
  logic rd_q;
  logic ctl_digital;
  logic slave_on;
  logic wr_act;
  logic rd_act;
  logic ext_wr_start;
  logic ext_rd_end;
  logic acc_wr;
  logic acc_rd;
  logic in_full_clr;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= 11'h7ff;
      pin_sync <= 11'h7ff;
    end
    else
    begin
      pin_meta <= {ifc.ctl, ifc.data};
      pin_sync <= pin_meta;
    end
  end

  assign pins_d = pin_sync[7:0];
  assign pins_e = pin_sync[10:8];
  assign ctl_digital = &analog_cfg[2:0];
  assign slave_on = mode & (&ctl_dir) & ctl_digital;
  assign wr_act = slave_on & ~pins_e[PIN_CS] & ~pins_e[PIN_WR];
  assign rd_act = slave_on & ~pins_e[PIN_CS] & ~pins_e[PIN_RD];
  assign ext_wr_start = wr_act & ~wr_q;
  assign ext_rd_end = rd_q & ~rd_act;
  assign acc_wr = psel & penable & pwrite;
  assign acc_rd = psel & penable & ~pwrite;
  assign in_full_clr = acc_rd & (paddr == OFS_DATA_PORT) & slave_on;

  assign pready = 1'b1;
  assign irq = irq_flag & irq_en;
  assign irq_high_priority = irq & irq_prio;
  assign ifc.ctl_dev_oe = ~ctl_dir;
  assign ifc.ctl_dev_out = ctl_latch;
  assign ifc.data_dev_out = data_latch;
  assign ifc.data_dev_oe = data_oe;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      data_oe <= RST_ZERO;
    end
    else
    begin
      wr_q <= wr_act;
      rd_q <= rd_act;
      data_oe <= slave_on ? {8{rd_act}} : ~data_dir;
    end
  end

  // Software-owned configuration.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_latch <= RST_ZERO;
      data_dir <= RST_DATA_DIR;
      ctl_latch <= 3'h0;
      ctl_dir <= RST_CTL_DIR;
      mode <= 1'b0;
      core_irq <= RST_ZERO;
      irq_en <= 1'b0;
      irq_prio <= 1'b0;
      analog_cfg <= RST_ZERO;
    end
    else if (acc_wr)
    begin
      case (paddr)
        OFS_DATA_PORT, OFS_DATA_LATCH: data_latch <= pwdata[7:0];
        OFS_DATA_DIR: data_dir <= pwdata[7:0];
        OFS_CTL_PORT, OFS_CTL_LATCH: ctl_latch <= pwdata[2:0];
        OFS_CTL_STATUS:
        begin
          mode <= pwdata[BIT_MODE];
          ctl_dir <= pwdata[2:0];
        end
        OFS_CORE_IRQ: core_irq <= pwdata[7:0];
        OFS_IRQ_ENABLE: irq_en <= pwdata[BIT_SLV_IRQ];
        OFS_IRQ_PRIO: irq_prio <= pwdata[BIT_SLV_IRQ];
        OFS_ANALOG_CFG: analog_cfg <= pwdata[7:0] & ANALOG_CFG_MASK;
        default: mode <= mode;
      endcase
    end
  end

  // Status flags: a hardware set always beats a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      input_buffer_full <= 1'b0;
      output_buffer_full <= 1'b0;
      input_overflow <= 1'b0;
      in_buf <= RST_ZERO;
      irq_flag <= 1'b0;
    end
    else
    begin
      if (ext_wr_start)
      begin
        input_buffer_full <= 1'b1;
        in_buf <= pins_d;
      end
      else if (in_full_clr)
      begin
        input_buffer_full <= 1'b0;
      end
      if (ext_wr_start && input_buffer_full && !in_full_clr)
      begin
        input_overflow <= 1'b1;
      end
      else if (acc_wr && paddr == OFS_CTL_STATUS && !pwdata[BIT_IN_OVERFLOW])
      begin
        input_overflow <= 1'b0;
      end
      if (acc_wr && paddr == OFS_DATA_PORT && slave_on)
      begin
        output_buffer_full <= 1'b1;
      end
      else if (ext_rd_end)
      begin
        output_buffer_full <= 1'b0;
      end
      if (ext_wr_start || ext_rd_end)
      begin
        irq_flag <= 1'b1;
      end
      else if (acc_wr && paddr == OFS_IRQ_FLAG && pwdata[BIT_SLV_IRQ])
      begin
        irq_flag <= 1'b0;
      end
    end
  end

  // Read data is registered in the setup phase so it is stable through the access phase.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pslverr <= 1'b0;
      prdata <= 32'h0;
      case (paddr)
        OFS_DATA_PORT: prdata[7:0] <= slave_on ? in_buf : pins_d;
        OFS_DATA_LATCH: prdata[7:0] <= data_latch;
        OFS_DATA_DIR: prdata[7:0] <= data_dir;
        OFS_CTL_PORT: prdata[2:0] <= ctl_digital ? pins_e : 3'h0;
        OFS_CTL_LATCH: prdata[2:0] <= ctl_latch;
        OFS_CTL_STATUS:
          prdata[7:0] <= {input_buffer_full, output_buffer_full, input_overflow,
            mode, 1'b0, ctl_dir};
        OFS_CORE_IRQ: prdata[7:0] <= core_irq;
        OFS_IRQ_FLAG: prdata[BIT_SLV_IRQ] <= irq_flag;
        OFS_IRQ_ENABLE: prdata[BIT_SLV_IRQ] <= irq_en;
        OFS_IRQ_PRIO: prdata[BIT_SLV_IRQ] <= irq_prio;
        OFS_ANALOG_CFG: prdata[7:0] <= analog_cfg;
        default: pslverr <= 1'b1;
      endcase
    end
  end
endmodule // pslv_device
`default_nettype wire

// [tb/pslv_monitor.sv]
// Checker for the pin link between the slave port and its host.
`timescale 1ns/10ps
`default_nettype none
module pslv_monitor
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link signals
  input wire logic [7:0] data_dev_oe,
  input wire logic [7:0] data_host_out,
  input wire logic data_host_oe,
  input wire logic [2:0] ctl_dev_oe,
  input wire logic [2:0] ctl_host_out,
  input wire logic [7:0] data
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_rst_released: assert property ($rose(presetn) |-> ctl_dev_oe == 3'h0)
    else $error("control pins driven after reset");
  chk_wr_selects: assert property (!ctl_host_out[1] |-> !ctl_host_out[2])
    else $error("write strobe without select");
  chk_rd_selects: assert property (!ctl_host_out[0] |-> !ctl_host_out[2])
    else $error("read strobe without select");
  chk_wr_strobe_len: assert property ($fell(ctl_host_out[1]) |->
    !ctl_host_out[1] [*8] ##1 ctl_host_out[1])
    else $error("write strobe length wrong");
  chk_rd_strobe_len: assert property ($fell(ctl_host_out[0]) |->
    !ctl_host_out[0] [*8] ##1 ctl_host_out[0])
    else $error("read strobe length wrong");
  chk_wr_data_held: assert property (!ctl_host_out[1] |->
    data_host_oe && data == data_host_out)
    else $error("write data not on the bus");
  chk_rd_port_drive: assert property ($fell(ctl_host_out[0]) |->
    ##4 data_dev_oe == 8'hff && !data_host_oe)
    else $error("port not driven during read");
  chk_cs_recover: assert property ($rose(ctl_host_out[2]) |-> ctl_host_out[2] [*4])
    else $error("select gap too short");
endmodule // pslv_monitor
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench joining the slave port device and its host.
`timescale 1ns/10ps
`default_nettype none
module tb
  import pslv_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, x;
  logic pready, pslverr, irq, irq_hp, e;
  logic req_valid = 1'b0, req_write = 1'b0, req_ready, rsp_valid;
  logic [7:0] req_data = 8'h00, rsp_data;
  int fail_count = 0;
  int n_compared = 0;
  always #20 pclk = ~pclk;
  pslv_if pslv_if_inst ();
  pslv_device pslv_device_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .irq, .irq_high_priority(irq_hp),
    .ifc(pslv_if_inst.device));
  pslv_host pslv_host_inst (.pclk, .presetn, .req_valid, .req_write, .req_data,
    .req_ready, .rsp_valid, .rsp_data, .ifc(pslv_if_inst.host));
  pslv_monitor pslv_monitor_inst (.pclk, .presetn,
    .data_dev_oe(pslv_if_inst.data_dev_oe), .data_host_out(pslv_if_inst.data_host_out),
    .data_host_oe(pslv_if_inst.data_host_oe), .ctl_dev_oe(pslv_if_inst.ctl_dev_oe),
    .ctl_host_out(pslv_if_inst.ctl_host_out), .data(pslv_if_inst.data));
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask
  // Waits on req_ready (0) or rsp_valid (1); a hang ends the run.
  task automatic wait_on(input int which);
    for (int i = 0; i < 60; i++)
    begin
      @(posedge pclk);
      if ((which == 0 ? req_ready : rsp_valid) === 1'b1)
        return;
    end
    fail_count++;
    $display("MISMATCH wait %0d expected done seen timeout", which);
    summarize();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (pready !== 1'b1)
    begin
      fail_count++;
      $display("MISMATCH pready expected 1 seen %b", pready);
      summarize();
    end
    x = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(n, exp, x);
  endtask
  task automatic host(input logic w, input logic [7:0] d);
    @(posedge pclk);
    req_valid <= 1'b1;
    req_write <= w;
    req_data <= d;
    wait_on(0);
    req_valid <= 1'b0;
    wait_on(1);
    wait_on(0);
  endtask
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc("status", OFS_CTL_STATUS, 32'h07);
    apb(1'b1, OFS_CTL_STATUS, 32'hef);
    rdc("status", OFS_CTL_STATUS, 32'h07);
    rdc("ctl port", OFS_CTL_PORT, 32'h00);
    rdc("analog", OFS_ANALOG_CFG, 32'h00);
    rdc("dir", OFS_DATA_DIR, 32'hff);
    apb(1'b1, OFS_CTL_STATUS, 32'h17);
    host(1'b1, 8'h11);
    rdc("status", OFS_CTL_STATUS, 32'h17);
    apb(1'b1, OFS_ANALOG_CFG, 32'h07);
    rdc("ctl port", OFS_CTL_PORT, 32'h07);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h80);
    host(1'b1, 8'ha5);
    rdc("status", OFS_CTL_STATUS, 32'h97);
    rdc("flag", OFS_IRQ_FLAG, 32'h80);
    check("irq", 32'h1, {31'h0, irq});
    rdc("data", OFS_DATA_PORT, 32'ha5);
    rdc("status", OFS_CTL_STATUS, 32'h17);
    host(1'b1, 8'h3c);
    host(1'b1, 8'hc3);
    rdc("status", OFS_CTL_STATUS, 32'hb7);
    apb(1'b0, OFS_DATA_PORT, 32'h0);
    rdc("status", OFS_CTL_STATUS, 32'h37);
    apb(1'b1, OFS_CTL_STATUS, 32'h17);
    rdc("status", OFS_CTL_STATUS, 32'h17);
    apb(1'b1, OFS_IRQ_FLAG, 32'h80);
    rdc("flag", OFS_IRQ_FLAG, 32'h00);
    check("irq", 32'h0, {31'h0, irq});
    apb(1'b1, OFS_DATA_PORT, 32'h5a);
    rdc("status", OFS_CTL_STATUS, 32'h57);
    host(1'b0, 8'h00);
    check("host data", 32'h5a, {24'h0, rsp_data});
    rdc("status", OFS_CTL_STATUS, 32'h17);
    apb(1'b1, OFS_IRQ_PRIO, 32'h80);
    rdc("flag", OFS_IRQ_FLAG, 32'h80);
    check("irq prio", 32'h1, {31'h0, irq_hp});
    apb(1'b1, OFS_IRQ_ENABLE, 32'h00);
    rdc("enable", OFS_IRQ_ENABLE, 32'h00);
    check("irq", 32'h0, {31'h0, irq});
    apb(1'b0, 8'h2c, 32'h0);
    check("slverr", 32'h1, {31'h0, e});
    apb(1'b1, OFS_CTL_STATUS, 32'h07);
    apb(1'b1, OFS_DATA_LATCH, 32'h3c);
    apb(1'b1, OFS_DATA_DIR, 32'h00);
    // Pin levels reach the port register only after the two-stage synchroniser.
    repeat (3) @(posedge pclk);
    rdc("pins", OFS_DATA_PORT, 32'h3c);
    apb(1'b1, OFS_DATA_DIR, 32'hff);
    repeat (3) @(posedge pclk);
    rdc("pins", OFS_DATA_PORT, 32'hff);
    apb(1'b1, OFS_CTL_LATCH, 32'h02);
    apb(1'b1, OFS_CTL_STATUS, 32'h00);
    repeat (3) @(posedge pclk);
    rdc("ctl pins", OFS_CTL_PORT, 32'h02);
    rdc("ctl latch", OFS_CTL_LATCH, 32'h02);
    summarize();
  end
endmodule // tb
`default_nettype wire
